// file: rtl/ssld_pkg.sv
/*
 Package for the serial shift/latch tube driver link: word width and timing counts.
 Assumes a 20 MHz system clock on both ends.
*/
package ssld_pkg;
    localparam int WORD_BITS     = 20;
    localparam int SYS_CLK_HZ    = 20_000_000;
    localparam int LINK_MAX_HZ   = 4_000_000;
    // Half period of the made link clock, rounded up so the rate never exceeds the limit
    localparam int LINK_HALF_CYC = (SYS_CLK_HZ + 2 * LINK_MAX_HZ - 1) / (2 * LINK_MAX_HZ);
    localparam int LOAD_HIGH_NS  = 55;
    localparam int LOAD_HIGH_CYC = (LOAD_HIGH_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DIV_BITS      = 4;
endpackage : ssld_pkg

// file: rtl/ssld_link_if.sv
/*
 Link between the host and the driver: clock, data, load, blank and serial out.
 Assumes the testbench chains serial out where cascading is wanted.
*/
`timescale 1ns/1ps
interface ssld_link_if;
    logic linkClk;
    logic serData;
    logic loadStrobe;
    logic blank;
    logic serOut;
    modport host (output linkClk, output serData, output loadStrobe, output blank, input serOut);
    modport device (input linkClk, input serData, input loadStrobe, input blank, output serOut);
endinterface : ssld_link_if

// file: rtl/ssld_sync.sv
/*
 Two-stage synchroniser for one level from outside the clock domain.
 Assumes sys_clk is the destination clock.
*/
`timescale 1ns/1ps
module ssld_sync (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_q;
    logic stage1_d;
    logic stage2_q;
    logic stage2_d;

    always_comb begin
        stage1_d = asyncIn;
        stage2_d = stage1_q;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= stage1_d;
            stage2_q <= stage2_d;
        end
    end

    assign syncOut = stage2_q;
endmodule : ssld_sync

// file: rtl/ssld_device.sv
/*
 Driver end: 20-bit shift register, transparent output latch, blanking and serial out.
 Assumes link pins are asynchronous; they are synchronised to sys_clk before use.
*/
`timescale 1ns/1ps
module ssld_device #(
    parameter int WIDTH = ssld_pkg::WORD_BITS
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    ssld_link_if.device     link,
    output logic [WIDTH-1:0] driverOutputs,
    output logic [WIDTH-1:0] latchValue
);
    logic             clkSync;
    logic             dataSync;
    logic             loadSync;
    logic             blankSync;
    logic             clkPrev_q;
    logic             clkPrev_d;
    logic [WIDTH-1:0] shift_q;
    logic [WIDTH-1:0] shift_d;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic             serOut_q;
    logic             serOut_d;
    logic [WIDTH-1:0] outs_q;
    logic [WIDTH-1:0] outs_d;

    ssld_sync u_clk   (.sys_clk(sys_clk), .reset(reset), .asyncIn(link.linkClk),    .syncOut(clkSync));
    ssld_sync u_data  (.sys_clk(sys_clk), .reset(reset), .asyncIn(link.serData),    .syncOut(dataSync));
    ssld_sync u_load  (.sys_clk(sys_clk), .reset(reset), .asyncIn(link.loadStrobe), .syncOut(loadSync));
    ssld_sync u_blank (.sys_clk(sys_clk), .reset(reset), .asyncIn(link.blank),      .syncOut(blankSync));

    // ==========================================================
    // Shift, latch and output
    always_comb begin
        clkPrev_d = clkSync;
        shift_d   = shift_q;
        serOut_d  = serOut_q;
        if (clkSync && !clkPrev_q) begin
            // Data is sampled with the same sync delay as the clock edge
            shift_d  = {shift_q[WIDTH-2:0], dataSync};
            serOut_d = shift_q[WIDTH-1];
        end
        // Transparent while load high; holds when load falls
        latch_d = loadSync ? shift_d : latch_q;
        outs_d  = blankSync ? '0 : latch_d;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clkPrev_q <= 1'b0;
            shift_q   <= '0;
            latch_q   <= '0;
            serOut_q  <= 1'b0;
            outs_q    <= '0;
        end else begin
            clkPrev_q <= clkPrev_d;
            shift_q   <= shift_d;
            latch_q   <= latch_d;
            serOut_q  <= serOut_d;
            outs_q    <= outs_d;
        end
    end

    assign link.serOut   = serOut_q;
    assign driverOutputs = outs_q;
    assign latchValue    = latch_q;
endmodule : ssld_device

// file: rtl/ssld_host.sv
/*
 Host end: shifts a word out top bit first with a divided link clock, then pulses load.
 Assumes wordIn is valid with startReq; it is captured when the request is accepted.
*/
`timescale 1ns/1ps
module ssld_host #(
    parameter int WIDTH = ssld_pkg::WORD_BITS
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    ssld_link_if.host             link,
    input  wire logic             startReq,
    input  wire logic [WIDTH-1:0] wordIn,
    input  wire logic             blankIn,
    output logic                  busy,
    output logic                  done
);
    typedef enum logic [1:0] {SSLD_IDLE, SSLD_LOW, SSLD_HIGH, SSLD_LOAD} ssld_state_type;

    localparam logic [ssld_pkg::DIV_BITS-1:0] HALF_LAST = ssld_pkg::DIV_BITS'(ssld_pkg::LINK_HALF_CYC - 1);
    localparam logic [ssld_pkg::DIV_BITS-1:0] LOAD_LAST = ssld_pkg::DIV_BITS'(ssld_pkg::LOAD_HIGH_CYC + 1);
    localparam logic [4:0]                    BIT_LAST  = 5'(WIDTH - 1);

    ssld_state_type            state_q;
    ssld_state_type            state_d;
    logic [ssld_pkg::DIV_BITS-1:0] div_q;
    logic [ssld_pkg::DIV_BITS-1:0] div_d;
    logic [4:0]                bit_q;
    logic [4:0]                bit_d;
    logic [WIDTH-1:0]          word_q;
    logic [WIDTH-1:0]          word_d;
    logic                      clk_q;
    logic                      clk_d;
    logic                      load_q;
    logic                      load_d;
    logic                      blank_q;
    logic                      blank_d;
    logic                      done_q;
    logic                      done_d;

    // ==========================================================
    // Write sequencer
    always_comb begin
        state_d = state_q;
        div_d   = div_q + 1'b1;
        bit_d   = bit_q;
        word_d  = word_q;
        clk_d   = clk_q;
        load_d  = load_q;
        blank_d = blankIn;
        done_d  = 1'b0;
        unique case (state_q)
            SSLD_IDLE: begin
                div_d = '0;
                clk_d = 1'b0;
                if (startReq) begin
                    word_d  = wordIn;
                    bit_d   = '0;
                    state_d = SSLD_LOW;
                end
            end
            SSLD_LOW: begin
                // Data changes in the low phase for setup before the rise
                if (div_q == HALF_LAST) begin
                    div_d   = '0;
                    clk_d   = 1'b1;
                    state_d = SSLD_HIGH;
                end
            end
            SSLD_HIGH: begin
                if (div_q == HALF_LAST) begin
                    div_d  = '0;
                    clk_d  = 1'b0;
                    word_d = {word_q[WIDTH-2:0], 1'b0};
                    if (bit_q == BIT_LAST) begin
                        load_d  = 1'b1;
                        state_d = SSLD_LOAD;
                    end else begin
                        bit_d   = bit_q + 1'b1;
                        state_d = SSLD_LOW;
                    end
                end
            end
            SSLD_LOAD: begin
                // Extra cycles cover the device's sync delay on load
                if (div_q == LOAD_LAST) begin
                    load_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = SSLD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= SSLD_IDLE;
            div_q   <= '0;
            bit_q   <= '0;
            word_q  <= '0;
            clk_q   <= 1'b0;
            load_q  <= 1'b0;
            blank_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q   <= div_d;
            bit_q   <= bit_d;
            word_q  <= word_d;
            clk_q   <= clk_d;
            load_q  <= load_d;
            blank_q <= blank_d;
            done_q  <= done_d;
        end
    end

    assign link.linkClk    = clk_q;
    assign link.serData    = word_q[WIDTH-1];
    assign link.loadStrobe = load_q;
    assign link.blank      = blank_q;
    assign busy            = (state_q != SSLD_IDLE);
    assign done            = done_q;
endmodule : ssld_host

// file: sim/ssld_link_properties.sv
/* Checker for the host to driver link wires.
   Assumes one sys_clk domain, synchronous active-high reset. */
`timescale 1ns/1ps
module ssld_link_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic linkClk,
    input wire logic serData,
    input wire logic loadStrobe,
    input wire logic blank,
    input wire logic serOut
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ==========================================
    // Link clock rises since the last load
    logic       prevClk_q;
    logic [5:0] riseCnt_q;
    logic [5:0] riseCnt_d;
    always_comb begin
        riseCnt_d = riseCnt_q;
        if (loadStrobe) begin
            riseCnt_d = 6'h00;
        end else if (linkClk && !prevClk_q) begin
            riseCnt_d = riseCnt_q + 6'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        prevClk_q <= reset ? 1'b0 : linkClk;
        riseCnt_q <= reset ? 6'h00 : riseCnt_d;
    end
    // ==========================================
    // Properties
    AST_RESET_IDLE: assert property ($fell(reset) |-> !serOut && !linkClk && !loadStrobe && !blank)
        else $error("link not idle after reset");
    AST_DATA_AT_LOW: assert property ($changed(serData) |-> !linkClk)
        else $error("data moved while link clock high");
    AST_CLK_HALF: assert property ($rose(linkClk) |=> linkClk [*2] ##1 !linkClk)
        else $error("link clock high phase not three cycles");
    AST_LOAD_WIDTH: assert property ($rose(loadStrobe) |=> loadStrobe [*3] ##1 !loadStrobe)
        else $error("load pulse not four cycles");
    AST_LOAD_CLK_LOW: assert property (loadStrobe |-> !linkClk)
        else $error("link clock high during load");
    AST_BITS_PER_WORD: assert property ($rose(loadStrobe) |-> riseCnt_q == 6'h14)
        else $error("load after wrong bit count");
    AST_LOAD_FOLLOWS: assert property ((riseCnt_q == 6'h14) && $fell(linkClk) |-> ##[0:8] loadStrobe)
        else $error("load missing after last bit");
    AST_SEROUT_TIMING: assert property ($changed(serOut) |-> $past(linkClk, 3) || $past(linkClk, 4))
        else $error("serial out moved without link clock");
endmodule : ssld_link_properties

// file: sim/test_serial_shift_latch_driver_if.sv
/* Testbench: host and driver on one link, plus a driver on a link driven here.
   Assumes package defaults; no count needs shortening. */
`timescale 1ns/1ps
module test_serial_shift_latch_driver_if;
    logic        sys_clk  = 1'b0;
    logic        reset    = 1'b1;
    logic        startReq = 1'b0;
    logic [19:0] wordIn   = 20'h00000;
    logic        blankIn  = 1'b0;
    logic        busy;
    logic        done;
    logic [19:0] outA, latchA, outB, latchB;
    logic [24:0] pat      = 25'h1b2c3d4;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    ssld_link_if lk ();
    ssld_link_if rawLk ();
    ssld_host ssld_host_inst (.sys_clk(sys_clk), .reset(reset), .link(lk.host), .startReq(startReq),
        .wordIn(wordIn), .blankIn(blankIn), .busy(busy), .done(done));
    ssld_device ssld_device_inst (.sys_clk(sys_clk), .reset(reset), .link(lk.device),
        .driverOutputs(outA), .latchValue(latchA));
    ssld_device ssld_device_inst2 (.sys_clk(sys_clk), .reset(reset), .link(rawLk.device),
        .driverOutputs(outB), .latchValue(latchB));
    ssld_link_properties ssld_link_properties_inst (.sys_clk(sys_clk), .reset(reset), .linkClk(lk.linkClk),
        .serData(lk.serData), .loadStrobe(lk.loadStrobe), .blank(lk.blank), .serOut(lk.serOut));
    always #25 sys_clk = ~sys_clk;
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("Checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic write_word(input logic [19:0] w);
        int n;
        @(negedge sys_clk);
        wordIn = w;
        startReq = 1'b1;
        @(negedge sys_clk);
        startReq = 1'b0;
        check("busyStart", 20'(busy), 20'h1);
        for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge sys_clk);
        check("doneSeen", 20'(done), 20'h1);
        check("busyEnd", 20'(busy), 20'h0);
        repeat (4) @(negedge sys_clk);
    endtask : write_word
    // ==========================================
    // Link clock of 400 ns made here; data inverted after each clock fall
    task automatic raw_bit(input logic b);
        @(negedge sys_clk);
        rawLk.serData = b;
        repeat (3) @(negedge sys_clk);
        rawLk.linkClk = 1'b1;
        repeat (4) @(negedge sys_clk);
        rawLk.linkClk = 1'b0;
        rawLk.serData = ~b;
    endtask : raw_bit
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        rawLk.linkClk = 1'b0;
        rawLk.serData = 1'b0;
        rawLk.loadStrobe = 1'b0;
        rawLk.blank = 1'b0;
        repeat (16) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        check("outReset", outA, 20'h00000);
        check("serOutReset", 20'(lk.serOut), 20'h00000);
        write_word(20'h5a3c1);
        check("latchFirst", latchA, 20'h5a3c1);
        check("outFirst", outA, 20'h5a3c1);
        write_word(20'hc0ffe);
        check("outSecond", outA, 20'hc0ffe);
        check("serOutOld", 20'(lk.serOut), 20'h00001);
        blankIn = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("outBlank", outA, 20'h00000);
        write_word(20'h80001);
        check("latchBlank", latchA, 20'h80001);
        check("outStillBlank", outA, 20'h00000);
        blankIn = 1'b0;
        repeat (6) @(negedge sys_clk);
        check("outUnblank", outA, 20'h80001);
        for (int i = 24; i >= 0; i--) raw_bit(pat[i]);
        repeat (4) @(negedge sys_clk);
        check("rawLatchHeld", latchB, 20'h00000);
        check("rawSerOut", 20'(rawLk.serOut), 20'(pat[20]));
        rawLk.loadStrobe = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("rawLastBits", latchB, pat[19:0]);
        raw_bit(1'b1);
        repeat (4) @(negedge sys_clk);
        check("rawTransparent", outB, 20'h587a9);
        rawLk.loadStrobe = 1'b0;
        raw_bit(1'b0);
        repeat (4) @(negedge sys_clk);
        check("rawLatchKept", latchB, 20'h587a9);
        final_report();
    end
endmodule : test_serial_shift_latch_driver_if
